// ---- core/fcb_bus_cycle.sv ----
// One asynchronous flash bus cycle, read or write, timed in clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "fcb_map.svh"

module fcb_bus_cycle (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic is_write,
    input wire logic [18:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] dq_in,
    output logic [18:0] addr_out,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [15:0] dq_out,
    output logic dq_oe,
    output logic [15:0] rdata,
    output logic done
);
    import fcb_pkg::*;

    fcb_cyc_type state;
    logic [7:0] cnt;
    logic writing;
    logic [15:0] dq_meta;
    logic [15:0] dq_sync;

    // Read data only reaches the capture through two flops
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dq_meta <= 16'h0000;
            dq_sync <= 16'h0000;
        end else if (clk_en) begin
            dq_meta <= dq_in;
            dq_sync <= dq_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= CY_IDLE;
            cnt <= 8'h00;
            writing <= 1'b0;
            addr_out <= 19'h0_0000;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            dq_out <= 16'h0000;
            dq_oe <= 1'b0;
            rdata <= 16'h0000;
            done <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            unique case (state)
                CY_IDLE: begin
                    if (start) begin
                        writing <= is_write;
                        addr_out <= addr;
                        dq_out <= wdata;
                        dq_oe <= is_write;
                        ce_n <= 1'b0;
                        cnt <= `FCB_SETUP_CYC - 8'h01;
                        state <= CY_SETUP;
                    end
                end
                CY_SETUP: begin
                    if (cnt == 8'h00) begin
                        // Only one strobe per cycle, so read and write never overlap
                        if (writing) begin
                            we_n <= 1'b0;
                            cnt <= `FCB_PULSE_CYC - 8'h01;
                        end else begin
                            oe_n <= 1'b0;
                            // Two extra cycles cover the input synchroniser
                            cnt <= `FCB_ACCESS_CYC + 8'h01;
                        end
                        state <= CY_STROBE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                CY_STROBE: begin
                    if (cnt == 8'h00) begin
                        // Write strobe rises before chip enable; address and data held past it
                        we_n <= 1'b1;
                        oe_n <= 1'b1;
                        if (!writing) begin
                            rdata <= dq_sync;
                        end
                        cnt <= `FCB_HOLD_CYC - 8'h01;
                        state <= CY_HOLD;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                CY_HOLD: begin
                    if (cnt == 8'h00) begin
                        // Chip enable back high between cycles so status latch refreshes
                        ce_n <= 1'b1;
                        dq_oe <= 1'b0;
                        cnt <= `FCB_HOLD_CYC - 8'h01;
                        state <= CY_GAP;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                CY_GAP: begin
                    if (cnt == 8'h00) begin
                        done <= 1'b1;
                        state <= CY_IDLE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
            endcase
        end
    end

endmodule : fcb_bus_cycle
`default_nettype wire

// ---- core/fcb_host.sv ----
// Flash command host: AXI4-Lite registers in, flash command sequences out on the pins
//
// Notes on behaviour
// - 90h then reads return identifier values
// - 70h switches following reads to status
// - FFh, 50h, B0h, D0h are single writes
// - Erase is 20h then D0h in block
// - Program is 40h or 10h, then data
// - Host writes only defined command codes
// - Never output enable and write together
`timescale 1ns/1ps
`default_nettype none
`include "fcb_map.svh"

module fcb_host (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CLOCK_EN,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic [18:0] FLASH_ADDR,
    output logic FLASH_CE_N,
    output logic FLASH_OE_N,
    output logic FLASH_WE_N,
    output logic [15:0] FLASH_DQ_OUT,
    output logic FLASH_DQ_OE,
    input wire logic [15:0] FLASH_DQ_IN,
    output logic POWERDOWN_RESET_N,
    output logic UNLOCK_HIGH_SEL,
    output logic BOOT_UNLOCK,
    output logic BYTE_MODE_N,
    input wire logic DONE_FLAG_OD_IN
);
    import fcb_pkg::*;

    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic reg_wr;
    logic [18:0] cmd_addr;
    logic [15:0] cmd_wdata;
    logic [3:0] pins;
    fcb_op_type op;
    logic wait_rdy;
    fcb_seq_type seq;
    fcb_mode_type mode;
    logic [7:0] holdoff;
    logic busy;
    logic done_flag;
    logic err_flag;
    logic rdy_meta;
    logic rdy_sync;
    logic cyc_start;
    logic cyc_write;
    logic [15:0] cyc_data;
    logic [15:0] cyc_rdata;
    logic cyc_done;
    logic go;
    logic bad_op;
    logic [31:0] status_word;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order, response after both
    assign reg_wr = !AWREADY && !WREADY && !BVALID;

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= 2'b00;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (CLOCK_EN) begin
            if (AWVALID && AWREADY) begin
                aw_addr <= AWADDR;
                AWREADY <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_data <= WDATA;
                w_strb <= WSTRB;
                WREADY <= 1'b0;
            end
            if (reg_wr) begin
                BVALID <= 1'b1;
                unique case (aw_addr)
                    `FCB_OFS_CTRL, `FCB_OFS_ADDR, `FCB_OFS_WDATA, `FCB_OFS_STATUS,
                    `FCB_OFS_RDATA, `FCB_OFS_PINS: BRESP <= 2'b00;
                    default: BRESP <= 2'b10;
                endcase
            end
            if (BVALID && BREADY) begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    assign status_word = {25'h000_0000, mode, rdy_sync, err_flag, done_flag, busy};

    // Read channel
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= 2'b00;
        end else if (CLOCK_EN) begin
            if (ARVALID && ARREADY) begin
                ARREADY <= 1'b0;
                RVALID <= 1'b1;
                RRESP <= 2'b00;
                unique case (ARADDR)
                    `FCB_OFS_CTRL: RDATA <= {27'h000_0000, wait_rdy, op};
                    `FCB_OFS_ADDR: RDATA <= {13'h0000, cmd_addr};
                    `FCB_OFS_WDATA: RDATA <= {16'h0000, cmd_wdata};
                    `FCB_OFS_STATUS: RDATA <= status_word;
                    `FCB_OFS_RDATA: RDATA <= {16'h0000, cyc_rdata};
                    `FCB_OFS_PINS: RDATA <= {28'h000_0000, pins};
                    default: begin
                        RDATA <= 32'h0000_0000;
                        RRESP <= 2'b10;
                    end
                endcase
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
                ARREADY <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            cmd_addr <= `FCB_ADDR_RST;
            cmd_wdata <= `FCB_WDATA_RST;
            pins <= `FCB_PINS_RST;
        end else if (CLOCK_EN && reg_wr) begin
            unique case (aw_addr)
                `FCB_OFS_ADDR: cmd_addr <= 19'(merge({13'h0000, cmd_addr}, w_data, w_strb));
                `FCB_OFS_WDATA: cmd_wdata <= 16'(merge({16'h0000, cmd_wdata}, w_data, w_strb));
                `FCB_OFS_PINS: pins <= 4'(merge({28'h000_0000, pins}, w_data, w_strb));
                default: ;
            endcase
        end
    end

    // Power-down, boot-lock and byte-mode pin drivers, one flop after the register; power-down held low in reset
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            POWERDOWN_RESET_N <= 1'b0;
            UNLOCK_HIGH_SEL <= 1'b0;
            BOOT_UNLOCK <= 1'b0;
            BYTE_MODE_N <= 1'b1;
        end else if (CLOCK_EN) begin
            POWERDOWN_RESET_N <= pins[`FCB_PINS_RESET_BIT];
            UNLOCK_HIGH_SEL <= pins[`FCB_PINS_HIGH_BIT];
            BOOT_UNLOCK <= pins[`FCB_PINS_UNLOCK_BIT];
            BYTE_MODE_N <= pins[`FCB_PINS_BYTE_N_BIT];
        end
    end

    // Ready pin is asynchronous, so two flops first
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            rdy_meta <= 1'b0;
            rdy_sync <= 1'b0;
        end else if (CLOCK_EN) begin
            rdy_meta <= DONE_FLAG_OD_IN;
            rdy_sync <= rdy_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command start: only listed codes go out; others refused, also in power-down
    assign go = reg_wr && (aw_addr == `FCB_OFS_CTRL) && w_strb[0];
    assign bad_op = (w_data[`FCB_CTRL_OP_MSB:`FCB_CTRL_OP_LSB] > OP_RESUME)
        || !POWERDOWN_RESET_N || busy;
    assign busy = (seq != SQ_IDLE);

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            op <= OP_READ;
            wait_rdy <= 1'b0;
        end else if (CLOCK_EN && go && !bad_op) begin
            op <= fcb_op_type'(w_data[`FCB_CTRL_OP_MSB:`FCB_CTRL_OP_LSB]);
            wait_rdy <= w_data[`FCB_CTRL_WAIT_BIT];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            seq <= SQ_IDLE;
            cyc_start <= 1'b0;
            cyc_write <= 1'b0;
            cyc_data <= 16'h0000;
            holdoff <= 8'h00;
        end else if (CLOCK_EN) begin
            cyc_start <= 1'b0;
            unique case (seq)
                SQ_IDLE: begin
                    if (go && !bad_op) begin
                        cyc_start <= 1'b1;
                        cyc_write <= (w_data[`FCB_CTRL_OP_MSB:`FCB_CTRL_OP_LSB] != OP_READ);
                        unique case (fcb_op_type'(w_data[`FCB_CTRL_OP_MSB:`FCB_CTRL_OP_LSB]))
                            OP_ARRAY: cyc_data <= {8'h00, `FCB_CODE_ARRAY};
                            OP_IDENT: cyc_data <= {8'h00, `FCB_CODE_IDENT};
                            OP_STATUS: cyc_data <= {8'h00, `FCB_CODE_STATUS};
                            OP_CLEAR: cyc_data <= {8'h00, `FCB_CODE_CLEAR};
                            OP_ERASE: cyc_data <= {8'h00, `FCB_CODE_ERASE};
                            OP_PROG: cyc_data <= {8'h00, `FCB_CODE_PROG};
                            OP_PROG_ALT: cyc_data <= {8'h00, `FCB_CODE_PROG_ALT};
                            OP_SUSPEND: cyc_data <= {8'h00, `FCB_CODE_SUSPEND};
                            OP_RESUME: cyc_data <= {8'h00, `FCB_CODE_RESUME};
                            default: cyc_data <= 16'h0000;
                        endcase
                        seq <= SQ_FIRST;
                    end
                end
                SQ_FIRST: begin
                    if (cyc_done) begin
                        unique case (op)
                            OP_IDENT, OP_STATUS: begin
                                // Second cycle reads the identifier or status value
                                cyc_start <= 1'b1;
                                cyc_write <= 1'b0;
                                seq <= SQ_SECOND;
                            end
                            OP_ERASE: begin
                                // Confirm at the same in-block address
                                cyc_start <= 1'b1;
                                cyc_write <= 1'b1;
                                cyc_data <= {8'h00, `FCB_CODE_CONFIRM};
                                seq <= SQ_SECOND;
                            end
                            OP_PROG, OP_PROG_ALT: begin
                                cyc_start <= 1'b1;
                                cyc_write <= 1'b1;
                                cyc_data <= cmd_wdata;
                                seq <= SQ_SECOND;
                            end
                            default: seq <= SQ_IDLE;
                        endcase
                    end
                end
                SQ_SECOND: begin
                    if (cyc_done) begin
                        if (wait_rdy && (op == OP_ERASE || op == OP_PROG || op == OP_PROG_ALT)) begin
                            holdoff <= `FCB_HOLDOFF_CYC;
                            seq <= SQ_HOLDOFF;
                        end else begin
                            seq <= SQ_IDLE;
                        end
                    end
                end
                SQ_HOLDOFF: begin
                    // Give the device time to pull the ready pin low first
                    if (holdoff == 8'h00) begin
                        seq <= SQ_WAIT;
                    end else begin
                        holdoff <= holdoff - 8'h01;
                    end
                end
                SQ_WAIT: begin
                    // Released pin reads high once the engine is idle
                    if (rdy_sync || !POWERDOWN_RESET_N) begin
                        seq <= SQ_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags: set wins over a write-one clear
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            done_flag <= 1'b0;
            err_flag <= 1'b0;
        end else if (CLOCK_EN) begin
            if (busy && (seq == SQ_IDLE || (seq == SQ_WAIT && rdy_sync) || cyc_done)
                && !(seq == SQ_FIRST && op inside {OP_IDENT, OP_STATUS, OP_ERASE,
                                                    OP_PROG, OP_PROG_ALT})
                && !(seq == SQ_SECOND && wait_rdy
                     && op inside {OP_ERASE, OP_PROG, OP_PROG_ALT})) begin
                done_flag <= 1'b1;
            end else if (reg_wr && aw_addr == `FCB_OFS_STATUS && w_strb[0]
                         && w_data[`FCB_ST_DONE_BIT]) begin
                done_flag <= 1'b0;
            end
            if (go && bad_op) begin
                err_flag <= 1'b1;
            end else if (reg_wr && aw_addr == `FCB_OFS_STATUS && w_strb[0]
                         && w_data[`FCB_ST_ERR_BIT]) begin
                err_flag <= 1'b0;
            end
        end
    end

    // Track what the device will return on a read
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            mode <= MD_ARRAY;
        end else if (CLOCK_EN) begin
            if (!POWERDOWN_RESET_N) begin
                mode <= MD_ARRAY;
            end else if (seq == SQ_FIRST && cyc_done) begin
                unique case (op)
                    OP_ARRAY: mode <= MD_ARRAY;
                    OP_IDENT: mode <= MD_IDENT;
                    OP_STATUS, OP_ERASE, OP_PROG, OP_PROG_ALT, OP_SUSPEND: mode <= MD_STATUS;
                    default: ;
                endcase
            end
        end
    end

    fcb_bus_cycle u_cycle (
        .clk(CLOCK),
        .nrst(NRST),
        .clk_en(CLOCK_EN),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(cmd_addr),
        .wdata(cyc_data),
        .dq_in(FLASH_DQ_IN),
        .addr_out(FLASH_ADDR),
        .ce_n(FLASH_CE_N),
        .oe_n(FLASH_OE_N),
        .we_n(FLASH_WE_N),
        .dq_out(FLASH_DQ_OUT),
        .dq_oe(FLASH_DQ_OE),
        .rdata(cyc_rdata),
        .done(cyc_done)
    );

endmodule : fcb_host
`default_nettype wire

// ---- core/fcb_map.svh ----
// Register offsets, field positions, command codes and bus timing of the flash command host
`ifndef FCB_MAP_SVH
`define FCB_MAP_SVH

`define FCB_OFS_CTRL 8'h00
`define FCB_OFS_ADDR 8'h04
`define FCB_OFS_WDATA 8'h08
`define FCB_OFS_STATUS 8'h0C
`define FCB_OFS_RDATA 8'h10
`define FCB_OFS_PINS 8'h14

`define FCB_CTRL_OP_LSB 0
`define FCB_CTRL_OP_MSB 3
`define FCB_CTRL_WAIT_BIT 4

`define FCB_ST_BUSY_BIT 0
`define FCB_ST_DONE_BIT 1
`define FCB_ST_ERR_BIT 2
`define FCB_ST_READY_BIT 3
`define FCB_ST_MODE_LSB 4
`define FCB_ST_MODE_MSB 6

`define FCB_PINS_RESET_BIT 0
`define FCB_PINS_UNLOCK_BIT 1
`define FCB_PINS_BYTE_N_BIT 2
`define FCB_PINS_HIGH_BIT 3
`define FCB_PINS_RST 4'h5
`define FCB_ADDR_RST 19'h0_0000
`define FCB_WDATA_RST 16'h0000

`define FCB_CODE_ARRAY 8'hFF
`define FCB_CODE_IDENT 8'h90
`define FCB_CODE_STATUS 8'h70
`define FCB_CODE_CLEAR 8'h50
`define FCB_CODE_ERASE 8'h20
`define FCB_CODE_CONFIRM 8'hD0
`define FCB_CODE_PROG 8'h40
`define FCB_CODE_PROG_ALT 8'h10
`define FCB_CODE_SUSPEND 8'hB0
`define FCB_CODE_RESUME 8'hD0

`define FCB_CLK_NS 20
`define FCB_SETUP_NS 20
`define FCB_PULSE_NS 50
`define FCB_ACCESS_NS 90
`define FCB_HOLD_NS 20
`define FCB_HOLDOFF_NS 200
`define FCB_CYC_MIN(ns) (((ns) + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_SETUP_CYC 8'(`FCB_CYC_MIN(`FCB_SETUP_NS))
`define FCB_PULSE_CYC 8'(`FCB_CYC_MIN(`FCB_PULSE_NS))
`define FCB_ACCESS_CYC 8'(`FCB_CYC_MIN(`FCB_ACCESS_NS))
`define FCB_HOLD_CYC 8'(`FCB_CYC_MIN(`FCB_HOLD_NS))
`define FCB_HOLDOFF_CYC 8'(`FCB_CYC_MIN(`FCB_HOLDOFF_NS))

`endif

// ---- core/fcb_pkg.sv ----
// Types shared by the flash command host and its bus cycle engine
`default_nettype none
package fcb_pkg;

    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_ARRAY = 4'h1,
        OP_IDENT = 4'h2,
        OP_STATUS = 4'h3,
        OP_CLEAR = 4'h4,
        OP_ERASE = 4'h5,
        OP_PROG = 4'h6,
        OP_PROG_ALT = 4'h7,
        OP_SUSPEND = 4'h8,
        OP_RESUME = 4'h9
    } fcb_op_type;

    typedef enum logic [4:0] {
        CY_IDLE = 5'b00001,
        CY_SETUP = 5'b00010,
        CY_STROBE = 5'b00100,
        CY_HOLD = 5'b01000,
        CY_GAP = 5'b10000
    } fcb_cyc_type;

    typedef enum logic [4:0] {
        SQ_IDLE = 5'b00001,
        SQ_FIRST = 5'b00010,
        SQ_SECOND = 5'b00100,
        SQ_HOLDOFF = 5'b01000,
        SQ_WAIT = 5'b10000
    } fcb_seq_type;

    typedef enum logic [2:0] {
        MD_ARRAY = 3'b001,
        MD_IDENT = 3'b010,
        MD_STATUS = 3'b100
    } fcb_mode_type;

endpackage : fcb_pkg
`default_nettype wire

// ---- tb/fcb_flash_model.sv ----
// Behavioural flash device answering the host's pin cycles
`timescale 1ns/1ps
`default_nettype none
module fcb_flash_model #(
    parameter logic [15:0] ID_MFR = 16'h00A5 // Arbitrary value
) (
    input wire logic [18:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [15:0] dq_host,
    input wire logic rst_n,
    input wire logic unlock,
    output logic [15:0] dq_dev,
    output logic ready_od
);
    logic [15:0] mem [0:15];
    logic [15:0] val;
    logic [7:0] setup = 8'h00, sr = 8'h00, sr_q;
    logic [1:0] mode = 2'd0;
    logic busy = 1'b0;
    always @(posedge we_n) begin
        if (!ce_n && rst_n) begin
            if (setup == 8'h20 && dq_host[7:0] != 8'hD0) sr = sr | 8'h30;
            else if (setup != 8'h00 && addr[18:13] == 6'h00 && !unlock) sr = sr | 8'h22;
            else if (setup == 8'h20) busy = 1'b1;
            else if (setup != 8'h00) begin
                mem[addr[3:0]] = dq_host;
                busy = 1'b1;
            end
            if (setup != 8'h00) begin
                mode = 2'd2;
                setup = 8'h00;
            end else case (dq_host[7:0])
                8'hFF: mode = 2'd0;
                8'h90: mode = 2'd1;
                8'h70: mode = 2'd2;
                8'h50: sr = 8'h00;
                8'h20, 8'h40, 8'h10: setup = dq_host[7:0];
                default: ;
            endcase
        end
    end
    always @(posedge busy) begin
        #2000;
        busy = 1'b0;
    end
    always @(negedge rst_n) begin
        busy = 1'b0;
        {mode, sr, setup} = '0;
    end
    always @(negedge oe_n) sr_q = {~busy, sr[6:0]};
    always @* begin
        case (mode)
            2'd0: val = mem[addr[3:0]];
            2'd1: val = ID_MFR;
            default: val = {8'h00, sr_q};
        endcase
    end
    // Released bus shows the inverse, so a stale sample cannot pass
    assign dq_dev = (!ce_n && !oe_n && we_n && rst_n) ? val : ~val;
    assign ready_od = !busy;
endmodule : fcb_flash_model
`default_nettype wire

// ---- tb/fcb_host_sva.sv ----
// Pin timing checker bound to the flash command host
`timescale 1ns/1ps
`default_nettype none
module fcb_host_sva (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic [18:0] FLASH_ADDR,
    input wire logic FLASH_CE_N,
    input wire logic FLASH_OE_N,
    input wire logic FLASH_WE_N,
    input wire logic FLASH_DQ_OE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    property p_excl; FLASH_OE_N || FLASH_WE_N; endproperty
    a_excl: assert property (p_excl) else $error("oe and we low");
    property p_wsel; !FLASH_WE_N |-> !FLASH_CE_N && FLASH_DQ_OE; endproperty
    a_wsel: assert property (p_wsel) else $error("write unselected");
    property p_wlen; $fell(FLASH_WE_N) |-> !FLASH_WE_N [*3] ##1 FLASH_WE_N; endproperty
    a_wlen: assert property (p_wlen) else $error("write pulse");
    property p_rlen; $fell(FLASH_OE_N) |-> !FLASH_OE_N [*7] ##1 FLASH_OE_N; endproperty
    a_rlen: assert property (p_rlen) else $error("read pulse");
    property p_rbus; !FLASH_OE_N |-> !FLASH_DQ_OE && !FLASH_CE_N; endproperty
    a_rbus: assert property (p_rbus) else $error("bus driven on read");
    property p_wset; $fell(FLASH_WE_N) |-> !$past(FLASH_CE_N) && $stable(FLASH_ADDR); endproperty
    a_wset: assert property (p_wset) else $error("write setup");
    // Device latches on the strobe rise, so address and data must outlive it
    property p_whld;
        $rose(FLASH_WE_N) |-> !FLASH_CE_N && FLASH_DQ_OE && $stable(FLASH_ADDR);
    endproperty
    a_whld: assert property (p_whld) else $error("write hold");
    property p_idle; FLASH_CE_N |-> FLASH_OE_N && FLASH_WE_N; endproperty
    a_idle: assert property (p_idle) else $error("strobe unselected");
    c_wr: cover property ($rose(FLASH_WE_N));
    c_rd: cover property ($rose(FLASH_OE_N));
    c_rst: cover property ($rose(NRST));
endmodule : fcb_host_sva
bind fcb_host fcb_host_sva u_sva (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
// Bench: AXI4-Lite orders to the flash host, answered by a device model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [15:0] MFR = 16'h00A5; // Arbitrary identifier value
    logic CLOCK = 1'b0, NRST = 1'b0, CLOCK_EN = 1'b1;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0000_0000, RDATA, v;
    logic [3:0] WSTRB = 4'hF;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, FLASH_CE_N, FLASH_OE_N, FLASH_WE_N;
    logic FLASH_DQ_OE, POWERDOWN_RESET_N, UNLOCK_HIGH_SEL, BOOT_UNLOCK, BYTE_MODE_N;
    logic DONE_FLAG_OD_IN;
    logic [1:0] BRESP, RRESP, vr, vw;
    logic [18:0] FLASH_ADDR;
    logic [15:0] FLASH_DQ_OUT, FLASH_DQ_IN;
    int err_total = 0, compares = 0, cyc = 0;
    fcb_host uut (.*);
    fcb_flash_model #(.ID_MFR(MFR)) dev (.addr(FLASH_ADDR), .ce_n(FLASH_CE_N),
        .oe_n(FLASH_OE_N), .we_n(FLASH_WE_N), .dq_host(FLASH_DQ_OUT),
        .rst_n(POWERDOWN_RESET_N), .unlock(BOOT_UNLOCK), .dq_dev(FLASH_DQ_IN),
        .ready_od(DONE_FLAG_OD_IN));
    initial forever #10 CLOCK = ~CLOCK;
    task automatic stop_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        AWADDR <= a;
        WDATA <= d;
        {AWVALID, WVALID, BREADY} <= 3'b111;
        do begin
            @(posedge CLOCK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        vw = BRESP;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge CLOCK);
        ARADDR <= a;
        {ARVALID, RREADY} <= 2'b11;
        do begin
            @(posedge CLOCK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1);
        RREADY <= 1'b0;
        v = RDATA;
        vr = RRESP;
    endtask : rd
    task automatic look(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        compares++;
        if ((v & m) !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h, expected %h", $time, v & m, e);
        end
    endtask : look
    // Done is sticky, so it is cleared after each order
    task automatic run(input logic [4:0] op);
        wr(8'h00, {27'h0, op});
        do rd(8'h0C); while (v[1] !== 1'b1);
        wr(8'h0C, 32'h0000_0006);
    endtask : run
    initial begin
        repeat (16) @(posedge CLOCK);
        NRST <= 1'b1;
        look(8'h14, 32'hFFFF_FFFF, 32'h0000_0005);
        wr(8'h04, 32'h0000_0000);
        run(5'h02);
        look(8'h10, 32'hFFFF_FFFF, {16'h0000, MFR});
        run(5'h15);
        run(5'h03);
        look(8'h10, 32'hFFFF_FFFF, 32'h0000_00A2);
        run(5'h04);
        run(5'h03);
        look(8'h10, 32'hFFFF_FFFF, 32'h0000_0080);
        for (int i = 0; i < 2; i++) begin
            wr(8'h04, 32'h0000_3000 + i);
            wr(8'h08, 32'h0000_5A00 + i);
            run(5'h16 + 5'(i));
            look(8'h0C, 32'h0000_0008, 32'h0000_0008);
            run(5'h01);
            run(5'h00);
            look(8'h10, 32'hFFFF_FFFF, 32'h0000_5A00 + i);
        end
        run(5'h08);
        look(8'h0C, 32'h0000_0070, 32'h0000_0040);
        run(5'h09);
        wr(8'h14, 32'h0000_0004);
        look(8'h0C, 32'h0000_0070, 32'h0000_0010);
        wr(8'h14, 32'h0000_0005);
        wr(8'h00, 32'h0000_000A);
        look(8'h0C, 32'h0000_0004, 32'h0000_0004);
        wr(8'h3C, 32'h0000_0000);
        look(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
        compares++;
        if (vr !== 2'b10 || vw !== 2'b10) begin
            err_total++;
            $display("wrong value at %0t: response", $time);
        end
        stop_test();
    end
endmodule : testbench
`default_nettype wire
